// ===== hdl/rtca_params.svh
// Register offsets, bit positions and timing counts of the calendar block
`ifndef RTCA_PARAMS_SVH
`define RTCA_PARAMS_SVH
// Byte offsets on the register bus
`define RTCA_OFF_CTRL 5'h00
`define RTCA_OFF_ALRM 5'h04
`define RTCA_OFF_TIME 5'h08
`define RTCA_OFF_DATE 5'h0c
`define RTCA_OFF_ATIME 5'h10
`define RTCA_OFF_ADATE 5'h14
// Clock control register bits
`define RTCA_ON_BIT 15
`define RTCA_WREN_BIT 3
`define RTCA_SYNC_BIT 2
`define RTCA_HALF_BIT 1
// Alarm control register bits
`define RTCA_AEN_BIT 15
`define RTCA_CHIME_BIT 14
`define RTCA_PIV_BIT 13
`define RTCA_ASYNC_BIT 12
`define RTCA_MASK_LSB 8
`define RTCA_ALARM_REPEAT_COUNT_LSB 0
// Value field low bits
`define RTCA_HR_LSB 24
`define RTCA_MIN_LSB 16
`define RTCA_SEC_LSB 8
`define RTCA_YR_LSB 24
`define RTCA_MON_LSB 16
`define RTCA_DAY_LSB 8
`define RTCA_WDAY_LSB 0
// BCD rollover limits and the repeat count wrap value
`define RTCA_SEC_TOP 8'h59
`define RTCA_HR_TOP 8'h23
`define RTCA_MON_TOP 8'h12
`define RTCA_YR_TOP 8'h99
`define RTCA_WDAY_TOP 3'h6
`define RTCA_ALARM_REPEAT_COUNT_MAX 8'hff
// Alarm interval codes
`define RTCA_AM_HALF 4'h0
`define RTCA_AM_SEC 4'h1
`define RTCA_AM_10SEC 4'h2
`define RTCA_AM_MIN 4'h3
`define RTCA_AM_10MIN 4'h4
`define RTCA_AM_HOUR 4'h5
`define RTCA_AM_DAY 4'h6
`define RTCA_AM_WEEK 4'h7
`define RTCA_AM_MONTH 4'h8
`define RTCA_AM_YEAR 4'h9
// Timing
`define RTCA_HALF_SEC_MS 500
`define RTCA_CLK_KHZ 100000
`define RTCA_HALF_SEC_CYC (`RTCA_HALF_SEC_MS * `RTCA_CLK_KHZ)
`define RTCA_SYNC_GUARD 32
`endif

// ===== hdl/rtca_pkg.sv
// Types of the calendar block: bus request, value fields and state
package rtca_pkg;
  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
  } rtca_avs_req_t;
  // BCD time of day
  typedef struct packed {
    logic [1:0] hours_tens;
    logic [3:0] hours_units;
    logic [2:0] minutes_tens;
    logic [3:0] minutes_units;
    logic [2:0] seconds_tens;
    logic [3:0] seconds_units;
  } rtca_time_t;
  // BCD date
  typedef struct packed {
    logic [3:0] years_tens;
    logic [3:0] years_units;
    logic months_tens;
    logic [3:0] months_units;
    logic [1:0] date_tens;
    logic [3:0] date_units;
    logic [2:0] weekday_value;
  } rtca_date_t;
  // Alarm control fields
  typedef struct packed {
    logic alarm_enable;
    logic chime;
    logic pulse_initial_level;
    logic [3:0] alarm_interval_select;
    logic [7:0] alarm_repeat_count;
  } rtca_actl_t;
  // Whole block state
  typedef struct packed {
    rtca_time_t tm;
    rtca_date_t dt;
    rtca_time_t atm;
    rtca_date_t adt;
    rtca_actl_t actl;
    logic on;
    logic wren;
    logic half_second_status;
    logic [25:0] presc;
    logic pulse;
    logic evt;
    logic tick;
    logic sec;
    logic busy;
    logic [31:0] rdata;
  } rtca_state_t;
endpackage

// ===== hdl/rtca_regs.sv
// Calendar, time and alarm registers with an Avalon-MM slave
`include "rtca_params.svh"

// Contract
// - Repeat count is triggers minus one
// - Each alarm event decrements repeat count
// - At zero, wrap to ff only with chime
// - Zero count without chime clears alarm enable
// - Hours BCD in bits 29-24
// - Minutes BCD in bits 22-16
// - Seconds BCD in bits 14-8
// - Time and date writes need write enable set
// - Year BCD in bits 31-24
// - Month BCD in bits 20-16
// - Day BCD in bits 13-8
// - Weekday in bits 2-0
// - Alarm time uses time layout
// - Alarm date has no year
// - Unused value bits read zero
// - Interval code selects alarm period
// - Seconds write clears half-second status
// - Pulse level writable only while disabled
// - Unsafe flag low when far from rollover
module rtca_regs #(
  parameter int unsigned HALF_CYCLES = `RTCA_HALF_SEC_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire rtca_pkg::rtca_avs_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic alarm_pulse,
  output logic alarm_event
);
  // Prescaler end and start of unsafe window
  localparam logic [25:0] LAST = 26'(HALF_CYCLES - 1);
  localparam logic [25:0] SAFE = 26'(HALF_CYCLES - 1 - `RTCA_SYNC_GUARD);

  // Reset image: bus idle holds waitrequest high
  localparam rtca_pkg::rtca_state_t RST_ST = '{busy: 1'b1, default: '0};

  rtca_pkg::rtca_state_t st_ff; // Registered state
  rtca_pkg::rtca_state_t nxt_st; // Next state
  logic acc; // Request accepted this cycle, answered the next
  logic sec_now; // Second boundary this cycle
  logic unsafe; // Near half-second rollover
  logic hit; // Alarm fields match
  logic [31:0] rd; // Read mux
  logic [31:0] wd; // Write data
  logic [7:0] sec_v; // Seconds as two digits
  logic [7:0] min_v; // Minutes as two digits
  logic [7:0] hr_v; // Hours as two digits
  logic [7:0] day_v; // Day as two digits
  logic [7:0] mon_v; // Month as two digits
  logic [7:0] yr_v; // Year as two digits
  logic [7:0] end_v; // Last day of month
  logic sec_eq; // Seconds match alarm
  logic min_eq; // Minutes match alarm
  logic hms_eq; // Whole time matches alarm

  // Step a two-digit BCD value, wrapping at top
  function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] top,
                                          input logic [7:0] base);
    if (v == top)
      return base;
    if (v[3:0] == 4'h9)
      return {v[7:4] + 4'h1, 4'h0};
    return v + 8'h01;
  endfunction

  // Last day of a month, leap years by BCD year
  function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  // Place time fields in a bus word, rest zero
  function automatic logic [31:0] pack_time(input rtca_pkg::rtca_time_t t);
    logic [31:0] w;
    w = '0;
    w[`RTCA_HR_LSB +: 6] = {t.hours_tens, t.hours_units};
    w[`RTCA_MIN_LSB +: 7] = {t.minutes_tens, t.minutes_units};
    w[`RTCA_SEC_LSB +: 7] = {t.seconds_tens, t.seconds_units};
    return w;
  endfunction

  // Place date fields in a bus word, year optional
  function automatic logic [31:0] pack_date(input rtca_pkg::rtca_date_t d, input logic yr);
    logic [31:0] w;
    w = '0;
    if (yr)
      w[`RTCA_YR_LSB +: 8] = {d.years_tens, d.years_units};
    w[`RTCA_MON_LSB +: 5] = {d.months_tens, d.months_units};
    w[`RTCA_DAY_LSB +: 6] = {d.date_tens, d.date_units};
    w[`RTCA_WDAY_LSB +: 3] = d.weekday_value;
    return w;
  endfunction

  // Digit views of the running time and alarm comparisons
  assign wd = avs_req.writedata;
  assign sec_v = {1'b0, st_ff.tm.seconds_tens, st_ff.tm.seconds_units};
  assign min_v = {1'b0, st_ff.tm.minutes_tens, st_ff.tm.minutes_units};
  assign hr_v = {2'b00, st_ff.tm.hours_tens, st_ff.tm.hours_units};
  assign day_v = {2'b00, st_ff.dt.date_tens, st_ff.dt.date_units};
  assign mon_v = {3'b000, st_ff.dt.months_tens, st_ff.dt.months_units};
  assign yr_v = {st_ff.dt.years_tens, st_ff.dt.years_units};
  assign end_v = month_end(mon_v, yr_v);
  assign sec_eq = {st_ff.tm.seconds_tens, st_ff.tm.seconds_units} ==
                  {st_ff.atm.seconds_tens, st_ff.atm.seconds_units};
  assign min_eq = {st_ff.tm.minutes_tens, st_ff.tm.minutes_units} ==
                  {st_ff.atm.minutes_tens, st_ff.atm.minutes_units};
  assign hms_eq = st_ff.tm == st_ff.atm;
  assign unsafe = st_ff.on && (st_ff.presc >= SAFE);

  // Alarm interval decode against the freshly updated time
  always_comb
  begin
    case (st_ff.actl.alarm_interval_select)
      `RTCA_AM_HALF: hit = 1'b1;
      `RTCA_AM_SEC: hit = st_ff.sec;
      `RTCA_AM_10SEC: hit = st_ff.sec && st_ff.tm.seconds_units == st_ff.atm.seconds_units;
      `RTCA_AM_MIN: hit = st_ff.sec && sec_eq;
      `RTCA_AM_10MIN: hit = st_ff.sec && sec_eq &&
                            st_ff.tm.minutes_units == st_ff.atm.minutes_units;
      `RTCA_AM_HOUR: hit = st_ff.sec && sec_eq && min_eq;
      `RTCA_AM_DAY: hit = st_ff.sec && hms_eq;
      `RTCA_AM_WEEK: hit = st_ff.sec && hms_eq &&
                           st_ff.dt.weekday_value == st_ff.adt.weekday_value;
      `RTCA_AM_MONTH: hit = st_ff.sec && hms_eq &&
                            {st_ff.dt.date_tens, st_ff.dt.date_units} ==
                            {st_ff.adt.date_tens, st_ff.adt.date_units};
      // Month and day only: the alarm date keeps no year
      `RTCA_AM_YEAR: hit = st_ff.sec && hms_eq &&
                           st_ff.dt[13:3] == st_ff.adt[13:3];
      default: hit = 1'b0; // Reserved codes never fire
    endcase
  end

  // Next state: time base, bus access, alarm
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.evt = 1'b0;
    nxt_st.tick = 1'b0;
    sec_now = 1'b0;
    rd = '0;
    acc = (avs_req.read | avs_req.write) & st_ff.busy;
    nxt_st.busy = ~acc;
    // Half-second prescaler, runs only when switched on
    if (st_ff.on)
    begin
      if (st_ff.presc == LAST)
      begin
        nxt_st.presc = '0;
        nxt_st.half_second_status = ~st_ff.half_second_status;
        nxt_st.tick = 1'b1;
        sec_now = st_ff.half_second_status;
      end
      else
        nxt_st.presc = st_ff.presc + 26'h1;
    end
    nxt_st.sec = sec_now;
    // Calendar ripple on each whole second
    if (sec_now)
    begin
      {nxt_st.tm.seconds_tens, nxt_st.tm.seconds_units} =
        7'(bcd_step(sec_v, `RTCA_SEC_TOP, 8'h00));
      if (sec_v == `RTCA_SEC_TOP)
      begin
        {nxt_st.tm.minutes_tens, nxt_st.tm.minutes_units} =
          7'(bcd_step(min_v, `RTCA_SEC_TOP, 8'h00));
        if (min_v == `RTCA_SEC_TOP)
        begin
          {nxt_st.tm.hours_tens, nxt_st.tm.hours_units} =
            6'(bcd_step(hr_v, `RTCA_HR_TOP, 8'h00));
          if (hr_v == `RTCA_HR_TOP)
          begin
            {nxt_st.dt.date_tens, nxt_st.dt.date_units} = 6'(bcd_step(day_v, end_v, 8'h01));
            nxt_st.dt.weekday_value = (st_ff.dt.weekday_value == `RTCA_WDAY_TOP) ? 3'h0 :
                                      st_ff.dt.weekday_value + 3'h1;
            if (day_v == end_v)
            begin
              {nxt_st.dt.months_tens, nxt_st.dt.months_units} =
                5'(bcd_step(mon_v, `RTCA_MON_TOP, 8'h01));
              if (mon_v == `RTCA_MON_TOP)
                {nxt_st.dt.years_tens, nxt_st.dt.years_units} =
                  bcd_step(yr_v, `RTCA_YR_TOP, 8'h00);
            end
          end
        end
      end
    end
    // Register writes
    if (acc && avs_req.write)
    begin
      case (avs_req.address)
        `RTCA_OFF_CTRL:
        begin
          nxt_st.wren = wd[`RTCA_WREN_BIT];
          if (st_ff.wren)
            nxt_st.on = wd[`RTCA_ON_BIT];
        end
        `RTCA_OFF_ALRM:
        begin
          nxt_st.actl.alarm_enable = wd[`RTCA_AEN_BIT];
          nxt_st.actl.chime = wd[`RTCA_CHIME_BIT];
          nxt_st.actl.alarm_interval_select = wd[`RTCA_MASK_LSB +: 4];
          nxt_st.actl.alarm_repeat_count = wd[`RTCA_ALARM_REPEAT_COUNT_LSB +: 8];
          // Start level of the pulse, frozen while enabled
          if (!st_ff.actl.alarm_enable)
          begin
            nxt_st.actl.pulse_initial_level = wd[`RTCA_PIV_BIT];
            nxt_st.pulse = wd[`RTCA_PIV_BIT];
          end
        end
        `RTCA_OFF_TIME:
        begin
          if (st_ff.wren)
          begin
            {nxt_st.tm.hours_tens, nxt_st.tm.hours_units} = wd[`RTCA_HR_LSB +: 6];
            {nxt_st.tm.minutes_tens, nxt_st.tm.minutes_units} = wd[`RTCA_MIN_LSB +: 7];
            {nxt_st.tm.seconds_tens, nxt_st.tm.seconds_units} = wd[`RTCA_SEC_LSB +: 7];
            nxt_st.half_second_status = 1'b0;
            nxt_st.presc = '0;
            nxt_st.sec = 1'b0;
          end
        end
        `RTCA_OFF_DATE:
        begin
          if (st_ff.wren)
          begin
            {nxt_st.dt.years_tens, nxt_st.dt.years_units} = wd[`RTCA_YR_LSB +: 8];
            {nxt_st.dt.months_tens, nxt_st.dt.months_units} = wd[`RTCA_MON_LSB +: 5];
            {nxt_st.dt.date_tens, nxt_st.dt.date_units} = wd[`RTCA_DAY_LSB +: 6];
            nxt_st.dt.weekday_value = wd[`RTCA_WDAY_LSB +: 3];
          end
        end
        `RTCA_OFF_ATIME:
        begin
          {nxt_st.atm.hours_tens, nxt_st.atm.hours_units} = wd[`RTCA_HR_LSB +: 6];
          {nxt_st.atm.minutes_tens, nxt_st.atm.minutes_units} = wd[`RTCA_MIN_LSB +: 7];
          {nxt_st.atm.seconds_tens, nxt_st.atm.seconds_units} = wd[`RTCA_SEC_LSB +: 7];
        end
        `RTCA_OFF_ADATE:
        begin
          {nxt_st.adt.months_tens, nxt_st.adt.months_units} = wd[`RTCA_MON_LSB +: 5];
          {nxt_st.adt.date_tens, nxt_st.adt.date_units} = wd[`RTCA_DAY_LSB +: 6];
          nxt_st.adt.weekday_value = wd[`RTCA_WDAY_LSB +: 3];
        end
        default:
        begin
          // Unmapped writes are dropped
        end
      endcase
    end
    // Register reads, unused bits zero
    case (avs_req.address)
      `RTCA_OFF_CTRL:
      begin
        rd[`RTCA_ON_BIT] = st_ff.on;
        rd[`RTCA_WREN_BIT] = st_ff.wren;
        rd[`RTCA_SYNC_BIT] = unsafe;
        rd[`RTCA_HALF_BIT] = st_ff.half_second_status;
      end
      `RTCA_OFF_ALRM:
      begin
        rd[`RTCA_AEN_BIT] = st_ff.actl.alarm_enable;
        rd[`RTCA_CHIME_BIT] = st_ff.actl.chime;
        rd[`RTCA_PIV_BIT] = st_ff.actl.alarm_enable ? st_ff.pulse :
                            st_ff.actl.pulse_initial_level;
        rd[`RTCA_ASYNC_BIT] = unsafe;
        rd[`RTCA_MASK_LSB +: 4] = st_ff.actl.alarm_interval_select;
        rd[`RTCA_ALARM_REPEAT_COUNT_LSB +: 8] = st_ff.actl.alarm_repeat_count;
      end
      `RTCA_OFF_TIME: rd = pack_time(st_ff.tm);
      `RTCA_OFF_DATE: rd = pack_date(st_ff.dt, 1'b1);
      `RTCA_OFF_ATIME: rd = pack_time(st_ff.atm);
      `RTCA_OFF_ADATE: rd = pack_date(st_ff.adt, 1'b0);
      default: rd = '0;
    endcase
    if (acc && avs_req.read)
      nxt_st.rdata = rd;
    // Alarm event: overrides a same-cycle control write
    if (st_ff.tick && st_ff.on && st_ff.actl.alarm_enable && hit)
    begin
      nxt_st.evt = 1'b1;
      nxt_st.pulse = ~st_ff.pulse;
      if (st_ff.actl.alarm_repeat_count != 8'h00)
        nxt_st.actl.alarm_repeat_count = st_ff.actl.alarm_repeat_count - 8'h01;
      else if (st_ff.actl.chime)
        nxt_st.actl.alarm_repeat_count = `RTCA_ALARM_REPEAT_COUNT_MAX;
      else
        nxt_st.actl.alarm_enable = 1'b0;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      st_ff <= RST_ST;
    else
      st_ff <= nxt_st;
  end

  // Outputs straight from the state register
  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = st_ff.busy;
  assign alarm_pulse = st_ff.pulse;
  assign alarm_event = st_ff.evt;

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_req;
    acc;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_ans;
    s_req |=> s_ans;
  endproperty
  a_ans: assert property (p_ans) else $error("answer not one cycle");

  property p_dec;
    st_ff.evt && $past(st_ff.actl.alarm_repeat_count) != 8'h00 |->
      st_ff.actl.alarm_repeat_count == $past(st_ff.actl.alarm_repeat_count) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("repeat count not decremented");

  property p_wrap;
    st_ff.evt && $past(st_ff.actl.alarm_repeat_count) == 8'h00 && $past(st_ff.actl.chime)
      |-> st_ff.actl.alarm_repeat_count == 8'hff;
  endproperty
  a_wrap: assert property (p_wrap) else $error("chime did not wrap count");

  property p_stop;
    st_ff.evt && $past(st_ff.actl.alarm_repeat_count) == 8'h00 && !$past(st_ff.actl.chime)
      |-> st_ff.actl.alarm_repeat_count == 8'h00 && !st_ff.actl.alarm_enable;
  endproperty
  a_stop: assert property (p_stop) else $error("last alarm left enabled");

  property p_lock;
    acc && avs_req.write && avs_req.address == `RTCA_OFF_TIME && !st_ff.wren && !sec_now
      |=> $stable(st_ff.tm);
  endproperty
  a_lock: assert property (p_lock) else $error("locked time was written");

  property p_half;
    acc && avs_req.write && avs_req.address == `RTCA_OFF_TIME && st_ff.wren
      |=> !st_ff.half_second_status;
  endproperty
  a_half: assert property (p_half) else $error("half-second not cleared");

  property p_piv;
    acc && avs_req.write && avs_req.address == `RTCA_OFF_ALRM && st_ff.actl.alarm_enable
      |=> $stable(st_ff.actl.pulse_initial_level);
  endproperty
  a_piv: assert property (p_piv) else $error("pulse level written while enabled");

  property p_sync;
    acc && avs_req.read && avs_req.address == `RTCA_OFF_ALRM && st_ff.presc < SAFE
      |=> !avs_readdata[`RTCA_ASYNC_BIT];
  endproperty
  a_sync: assert property (p_sync) else $error("unsafe flag high far from rollover");

  property p_zero;
    acc && avs_req.read && avs_req.address == `RTCA_OFF_ADATE
      |=> avs_readdata[31:21] == 11'h000 && avs_readdata[15:14] == 2'h0 &&
          avs_readdata[7:3] == 5'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("unused alarm date bits set");

  property p_evt;
    st_ff.evt |-> $past(st_ff.actl.alarm_enable) && $past(st_ff.tick);
  endproperty
  a_evt: assert property (p_evt) else $error("alarm fired while disabled");

  property p_mask;
    st_ff.actl.alarm_interval_select > `RTCA_AM_YEAR |=> !st_ff.evt;
  endproperty
  a_mask: assert property (p_mask) else $error("reserved interval fired");
endmodule

// ===== sim/rtca_regs_test.sv
// Self-checking bench for the calendar, time and alarm registers
`include "rtca_params.svh"

module rtca_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Short half second keeps the run brief
  localparam int unsigned HALF = 100;
  logic core_clk; // Bus clock
  logic nrst; // Reset, active low
  rtca_pkg::rtca_avs_req_t avs_req; // Bus request
  logic [31:0] avs_readdata; // Read data
  logic avs_waitrequest; // Bus stall
  logic alarm_pulse; // Alarm pulse level
  logic alarm_event; // One-cycle alarm strobe
  int failures; // Mismatch count
  int n_tests; // Comparison count
  int n_evt; // Alarm strobes seen
  int n0; // Strobe count at test start
  logic [31:0] q; // Last read word

  rtca_regs #(.HALF_CYCLES(HALF)) u_rtca_regs (
    .core_clk(core_clk),
    .nrst(nrst),
    .avs_req(avs_req),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .alarm_pulse(alarm_pulse),
    .alarm_event(alarm_event)
  );

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // Count alarm strobes as they pass
  always @(posedge core_clk)
  begin
    if (alarm_event === 1'b1)
      n_evt++;
  end

  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_req.read <= !wr;
    avs_req.write <= wr;
    avs_req.address <= a;
    avs_req.writedata <= d;
    // Every access must finish well inside the read window
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 32);
    if (avs_waitrequest !== 1'b0)
    begin
      failures++;
      $display("mismatch at %0t: bus stall %h exp %h", $time, avs_waitrequest, 1'b0);
    end
    q = avs_readdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
    // Let one edge pass before the next request
    @(posedge core_clk);
  endtask

  // Write a register
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // Read a register and compare the masked word
  task automatic rc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(q & m, exp);
  endtask

  // Wait for a strobe count, bounded
  task automatic wait_evt(input int target);
    int n;
    n = 0;
    while (n_evt < target && n < 1000)
    begin
      @(posedge core_clk);
      n++;
    end
  endtask

  // Counts, verdict and end of run
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog against a hung bus or lost strobe
  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    $display("watchdog expired at %0t", $time);
    close_out();
  end

  // Main sequence
  initial
  begin
    core_clk = 1'b0;
    nrst = 1'b0;
    avs_req = '0;
    failures = 0;
    n_tests = 0;
    n_evt = 0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    // Reset state
    rc(`RTCA_OFF_CTRL, 32'hffffffff, 32'h00000000);
    rc(`RTCA_OFF_ALRM, 32'hffffffff, 32'h00000000);
    $display("test reset done");
    // Locked time register ignores writes
    wr(`RTCA_OFF_TIME, 32'hd2b4d6ff);
    rc(`RTCA_OFF_TIME, 32'hffffffff, 32'h00000000);
    // Enable bit set, but the on bit stays locked in the same write
    wr(`RTCA_OFF_CTRL, 32'h00008008);
    rc(`RTCA_OFF_CTRL, 32'h0000800e, 32'h00000008);
    // Fields with every unused bit driven high
    wr(`RTCA_OFF_TIME, 32'hd2b4d6ff);
    rc(`RTCA_OFF_TIME, 32'hffffffff, 32'h12345600);
    wr(`RTCA_OFF_DATE, 32'h99f2f1fe);
    rc(`RTCA_OFF_DATE, 32'hffffffff, 32'h99123106);
    wr(`RTCA_OFF_ATIME, 32'hd2b4d7ff);
    rc(`RTCA_OFF_ATIME, 32'hffffffff, 32'h12345700);
    wr(`RTCA_OFF_ADATE, 32'hfff2f1fe);
    rc(`RTCA_OFF_ADATE, 32'hffffffff, 32'h00123106);
    // Unmapped places read zero
    wr(5'h18, 32'hffffffff);
    rc(5'h18, 32'hffffffff, 32'h00000000);
    rc(5'h1c, 32'hffffffff, 32'h00000000);
    $display("test layout done");
    // Start the time base, then look into the second half period
    wr(`RTCA_OFF_CTRL, 32'h00008008);
    repeat (120) @(posedge core_clk);
    rc(`RTCA_OFF_CTRL, 32'h0000800e, 32'h0000800a);
    // Seconds write clears the half-second status
    wr(`RTCA_OFF_TIME, 32'h12345600);
    rc(`RTCA_OFF_CTRL, 32'h0000800e, 32'h00008008);
    // Near the rollover the unsafe flag is up in both places
    repeat (70) @(posedge core_clk);
    rc(`RTCA_OFF_CTRL, 32'h0000800e, 32'h0000800c);
    rc(`RTCA_OFF_ALRM, 32'h00001000, 32'h00001000);
    $display("test time base done");
    // Fresh prescaler keeps alarm writes out of the unsafe window
    wr(`RTCA_OFF_TIME, 32'h12345600);
    wr(`RTCA_OFF_ALRM, 32'h00002000);
    chk({31'h0, alarm_pulse}, 32'h1);
    wr(`RTCA_OFF_ALRM, 32'h00000000);
    chk({31'h0, alarm_pulse}, 32'h0);
    // Count of two gives three strobes, then the alarm switches off
    n0 = n_evt;
    wr(`RTCA_OFF_ALRM, 32'h00008002);
    wait_evt(n0 + 3);
    repeat (350) @(posedge core_clk);
    chk(n_evt - n0, 32'h3);
    rc(`RTCA_OFF_ALRM, 32'h000080ff, 32'h00000000);
    chk({31'h0, alarm_pulse}, 32'h1);
    $display("test single alarm done");
    // Chime lets the count wrap from zero to all ones
    wr(`RTCA_OFF_TIME, 32'h12345600);
    wr(`RTCA_OFF_ALRM, 32'h00000000);
    n0 = n_evt;
    wr(`RTCA_OFF_ALRM, 32'h0000c000);
    wait_evt(n0 + 2);
    rc(`RTCA_OFF_ALRM, 32'h0000c0ff, 32'h0000c0fe);
    // Pulse level bit is ignored while the alarm runs
    wr(`RTCA_OFF_ALRM, 32'h0000e0fe);
    chk({31'h0, alarm_pulse}, 32'h0);
    wr(`RTCA_OFF_ALRM, 32'h00000000);
    $display("test chime done");
    // Interval codes 1 to 15: one match one second ahead, none when reserved
    for (int c = 1; c < 16; c++)
    begin
      wr(`RTCA_OFF_TIME, 32'h12345600);
      n0 = n_evt;
      wr(`RTCA_OFF_ALRM, 32'h00008000 | (c << 8));
      repeat (450) @(posedge core_clk);
      chk(n_evt - n0, (c <= 9) ? 32'h1 : 32'h0);
      wr(`RTCA_OFF_ALRM, 32'h00000000);
    end
    $display("test intervals done");
    close_out();
  end
endmodule
